// *** design/ccs_pkg.sv ***
// Purpose: shared constants and carriers for the core state register block
// Assumes: 32-bit data, register numbers 0..15 on the execution side
// Notes: special registers use coined select codes
package ccs_pkg;
  localparam int unsigned XLEN = 32;
  localparam logic [3:0] REG_SP = 4'hd;
  localparam logic [3:0] REG_LINK = 4'he;
  localparam logic [3:0] REG_PC = 4'hf;
  localparam logic [3:0] LOW_REG_LAST = 4'h7;
  localparam logic [3:0] HIGH_REG_LAST = 4'hc;
  // special register select codes
  localparam logic [3:0] SR_PSR_ALL = 4'h0;
  localparam logic [3:0] SR_APP = 4'h1;
  localparam logic [3:0] SR_EXCNUM = 4'h2;
  localparam logic [3:0] SR_EXEC = 4'h3;
  localparam logic [3:0] SR_MASK_ALL = 4'h4;
  localparam logic [3:0] SR_FAULT_MASK = 4'h5;
  localparam logic [3:0] SR_THRESH = 4'h6;
  localparam logic [3:0] SR_CONTROL = 4'h7;
  localparam logic [3:0] SR_MAIN_SP = 4'h8;
  localparam logic [3:0] SR_PROC_SP = 4'h9;
  // program status field layout
  localparam logic [31:0] APP_FIELD_MASK = 32'hf8000000;
  localparam logic [31:0] EXCNUM_FIELD_MASK = 32'h000001ff;
  localparam logic [31:0] EXEC_FIELD_MASK = 32'h0700fc00;
  localparam int unsigned EXEC_STATE_BIT = 24;
  localparam logic [31:0] PSR_RESET = 32'h01000000;
  localparam logic [31:0] SP_ALIGN_MASK = 32'hfffffffc;
  localparam logic [31:0] PC_ALIGN_MASK = 32'hfffffffe;
  localparam int unsigned THRESH_W = 9;
  localparam int unsigned CTRL_PRIV_BIT = 0;
  localparam int unsigned CTRL_STACK_BIT = 1;
  localparam logic [1:0] CTRL_RESET = 2'h0;
  localparam logic [31:0] SP_RESET = 32'h00000000;
  localparam logic [31:0] PC_RESET = 32'h00000000;
  // register bus addresses (special register file)
  localparam logic [3:0] BUS_SR_LAST = 4'h9;
  typedef enum logic [1:0] {
    CCS_EXC_NMI = 2'b00,
    CCS_EXC_HARD = 2'b01,
    CCS_EXC_OTHER = 2'b10,
    CCS_EXC_IRQ = 2'b11
  } ccs_exc_kind_t;
  typedef struct packed {
    logic valid;
    logic wide;
    logic [3:0] num;
    logic [31:0] data;
  } ccs_gpr_wr_t;
  typedef struct packed {
    logic valid;
    logic [3:0] sel;
    logic [31:0] data;
  } ccs_sr_wr_t;
  typedef struct packed {
    logic valid;
    ccs_exc_kind_t kind;
    logic [THRESH_W-1:0] prio;
  } ccs_exc_req_t;
endpackage : ccs_pkg

// *** design/ccs_core_state.sv ***
// Purpose: architectural register and mode state of the processor core
// Assumes: execution logic drives one gpr write, one special write per cycle
// Notes: software bus reaches special registers by select code as address
//
// What this block does
// - low registers reachable by every form
// - high registers only by 32-bit forms
// - process stack only user thread mode
// - stack pointer low two bits zero
// - call writes return address to link
// - program counter bit zero forced zero
// - app flags live in bits 27-31
// - exception number in bits 0-8
// - exec control in 10-15, 25-26
// - exec state bit stays one; clear faults
// - status parts accessed together or separately
// - global mask passes only nmi, hard fault
// - fault mask passes only nmi
// - threshold blocks irq of equal or lower urgency
// - zero threshold disables priority masking
// - control bit zero selects thread privilege
// - control bit one selects stack, handler zero
// - user write to protected state faults
// - handler mode privileged while servicing exception
module ccs_core_state
  import ccs_pkg::*;
#(
  parameter int unsigned GPR_COUNT = 13
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire ccs_gpr_wr_t gpr_wr_i,
  input wire logic [3:0] gpr_rd_num_i,
  input wire logic gpr_rd_wide_i,
  input wire ccs_sr_wr_t sr_wr_i,
  input wire logic call_i,
  input wire logic [31:0] call_return_i,
  input wire logic pc_load_i,
  input wire logic [31:0] pc_next_i,
  input wire logic exc_enter_i,
  input wire logic [8:0] exc_num_i,
  input wire logic exc_return_i,
  input wire ccs_exc_req_t exc_req_i,
  input wire logic [3:0] bus_addr_i,
  input wire logic [31:0] bus_wdata_i,
  input wire logic bus_we_i,
  input wire logic bus_re_i,
  output logic [31:0] bus_rdata_o,
  output logic [31:0] gpr_rd_data_o,
  output logic gpr_rd_fault_o,
  output logic [31:0] program_counter_o,
  output logic [31:0] program_status_o,
  output logic handler_mode_o,
  output logic user_level_o,
  output logic exc_accept_o,
  output logic fault_o
);
  logic [31:0] gpr_q [GPR_COUNT];
  logic [31:0] gpr_d [GPR_COUNT];
  logic [31:0] main_sp_q, main_sp_d, proc_sp_q, proc_sp_d;
  logic [31:0] link_q, link_d, pc_q, pc_d, psr_q, psr_d;
  logic mask_all_q, mask_all_d, fault_mask_q, fault_mask_d;
  logic [THRESH_W-1:0] thresh_q, thresh_d;
  logic [1:0] ctrl_q, ctrl_d;
  logic handler_q, handler_d;
  logic user_q, user_d;
  logic [31:0] rdata_q, rdata_d, gpr_rd_q, gpr_rd_d;
  logic gpr_fault_q, gpr_fault_d, accept_q, accept_d, fault_q, fault_d;
  logic use_proc_sp, user_now, sr_we, gpr_ok, wr_fault;
  logic [3:0] sr_sel;
  logic [31:0] sr_data, sp_now;

  assign user_now = !handler_q && ctrl_q[CTRL_PRIV_BIT];
  assign use_proc_sp = !handler_q && ctrl_q[CTRL_STACK_BIT] && user_now;
  assign sp_now = use_proc_sp ? proc_sp_q : main_sp_q;
  // bus writes win the special port only when execution leaves it idle
  assign sr_we = sr_wr_i.valid || bus_we_i;
  assign sr_sel = sr_wr_i.valid ? sr_wr_i.sel : bus_addr_i;
  assign sr_data = sr_wr_i.valid ? sr_wr_i.data : bus_wdata_i;
  assign gpr_ok = gpr_wr_i.wide || gpr_wr_i.num <= LOW_REG_LAST;

  function automatic logic [31:0] sr_read(input logic [3:0] sel);
    logic [31:0] v;
    v = 32'h0;
    unique case (sel)
      SR_PSR_ALL: v = psr_q;
      SR_APP: v = psr_q & APP_FIELD_MASK;
      SR_EXCNUM: v = psr_q & EXCNUM_FIELD_MASK;
      SR_EXEC: v = psr_q & EXEC_FIELD_MASK;
      SR_MASK_ALL: v = {31'h0, mask_all_q};
      SR_FAULT_MASK: v = {31'h0, fault_mask_q};
      SR_THRESH: v = {{(32 - THRESH_W){1'b0}}, thresh_q};
      SR_CONTROL: v = {30'h0, ctrl_q};
      SR_MAIN_SP: v = main_sp_q;
      SR_PROC_SP: v = proc_sp_q;
      default: v = 32'h0;
    endcase
    return v;
  endfunction : sr_read

  always_comb begin
    for (int i = 0; i < GPR_COUNT; i++) begin
      gpr_d[i] = gpr_q[i];
    end
    main_sp_d = main_sp_q;
    proc_sp_d = proc_sp_q;
    link_d = link_q;
    pc_d = pc_q;
    psr_d = psr_q;
    mask_all_d = mask_all_q;
    fault_mask_d = fault_mask_q;
    thresh_d = thresh_q;
    ctrl_d = ctrl_q;
    handler_d = handler_q;
    wr_fault = 1'b0;
    // general writes
    if (gpr_wr_i.valid) begin
      if (!gpr_ok) begin
        wr_fault = 1'b1;
      end else if (gpr_wr_i.num <= HIGH_REG_LAST) begin
        gpr_d[gpr_wr_i.num] = gpr_wr_i.data;
      end else if (gpr_wr_i.num == REG_SP) begin
        if (use_proc_sp) begin
          proc_sp_d = gpr_wr_i.data & SP_ALIGN_MASK;
        end else begin
          main_sp_d = gpr_wr_i.data & SP_ALIGN_MASK;
        end
      end else if (gpr_wr_i.num == REG_LINK) begin
        link_d = gpr_wr_i.data;
      end
    end
    if (call_i) begin
      link_d = call_return_i;
    end
    if (pc_load_i) begin
      pc_d = pc_next_i & PC_ALIGN_MASK;
    end else if (gpr_wr_i.valid && gpr_ok && gpr_wr_i.num == REG_PC) begin
      pc_d = gpr_wr_i.data & PC_ALIGN_MASK;
    end
    // special register writes
    if (sr_we) begin
      if (user_now && sr_sel != SR_APP && sr_sel != SR_PSR_ALL) begin
        wr_fault = 1'b1;
      end else begin
        unique case (sr_sel)
          SR_PSR_ALL, SR_APP: begin
            // user level may change only the flag field
            if (user_now || sr_sel == SR_APP) begin
              psr_d = (psr_q & ~APP_FIELD_MASK) | (sr_data & APP_FIELD_MASK);
            end else begin
              psr_d = sr_data & (APP_FIELD_MASK | EXCNUM_FIELD_MASK | EXEC_FIELD_MASK);
              psr_d[EXEC_STATE_BIT] = 1'b1;
              if (!sr_data[EXEC_STATE_BIT]) begin
                wr_fault = 1'b1;
              end
            end
          end
          SR_EXCNUM: psr_d = (psr_q & ~EXCNUM_FIELD_MASK) | (sr_data & EXCNUM_FIELD_MASK);
          SR_EXEC: begin
            psr_d = (psr_q & ~EXEC_FIELD_MASK) | (sr_data & EXEC_FIELD_MASK);
            if (!sr_data[EXEC_STATE_BIT]) begin
              wr_fault = 1'b1;
            end
          end
          SR_MASK_ALL: mask_all_d = sr_data[0];
          SR_FAULT_MASK: fault_mask_d = sr_data[0];
          SR_THRESH: thresh_d = sr_data[THRESH_W-1:0];
          SR_CONTROL: begin
            ctrl_d[CTRL_PRIV_BIT] = sr_data[CTRL_PRIV_BIT];
            ctrl_d[CTRL_STACK_BIT] = handler_q ? 1'b0 : sr_data[CTRL_STACK_BIT];
          end
          SR_MAIN_SP: main_sp_d = sr_data & SP_ALIGN_MASK;
          SR_PROC_SP: proc_sp_d = sr_data & SP_ALIGN_MASK;
          default: ;
        endcase
      end
    end
    // exception entry and return
    if (exc_enter_i) begin
      handler_d = 1'b1;
      psr_d = (psr_d & ~EXCNUM_FIELD_MASK) | {23'h0, exc_num_i};
    end else if (exc_return_i) begin
      handler_d = 1'b0;
      psr_d = psr_d & ~EXCNUM_FIELD_MASK;
    end
    psr_d[EXEC_STATE_BIT] = 1'b1;
  end

  always_comb begin
    accept_d = 1'b0;
    if (exc_req_i.valid) begin
      unique case (exc_req_i.kind)
        CCS_EXC_NMI: accept_d = 1'b1;
        CCS_EXC_HARD: accept_d = !fault_mask_q;
        default: begin
          accept_d = !fault_mask_q && !mask_all_q;
          if (exc_req_i.kind == CCS_EXC_IRQ && thresh_q != '0 && exc_req_i.prio >= thresh_q) begin
            accept_d = 1'b0;
          end
        end
      endcase
    end
    rdata_d = bus_re_i ? sr_read(bus_addr_i) : 32'h0;
    gpr_rd_d = 32'h0;
    gpr_fault_d = 1'b0;
    if (!gpr_rd_wide_i && gpr_rd_num_i > LOW_REG_LAST && gpr_rd_num_i <= HIGH_REG_LAST) begin
      gpr_fault_d = 1'b1;
    end else if (gpr_rd_num_i <= HIGH_REG_LAST) begin
      gpr_rd_d = gpr_q[gpr_rd_num_i];
    end else if (gpr_rd_num_i == REG_SP) begin
      gpr_rd_d = sp_now;
    end else if (gpr_rd_num_i == REG_LINK) begin
      gpr_rd_d = link_q;
    end else begin
      gpr_rd_d = pc_q;
    end
    fault_d = wr_fault;
    // registered so the level output carries no combinational path
    user_d = !handler_d && ctrl_d[CTRL_PRIV_BIT];
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      for (int i = 0; i < GPR_COUNT; i++) begin
        gpr_q[i] <= 32'h0;
      end
      main_sp_q <= SP_RESET;
      proc_sp_q <= SP_RESET;
      link_q <= 32'h0;
      pc_q <= PC_RESET;
      psr_q <= PSR_RESET;
      mask_all_q <= 1'b0;
      fault_mask_q <= 1'b0;
      thresh_q <= '0;
      ctrl_q <= CTRL_RESET;
      handler_q <= 1'b0;
      user_q <= 1'b0;
      rdata_q <= 32'h0;
      gpr_rd_q <= 32'h0;
      gpr_fault_q <= 1'b0;
      accept_q <= 1'b0;
      fault_q <= 1'b0;
    end else begin
      for (int i = 0; i < GPR_COUNT; i++) begin
        gpr_q[i] <= gpr_d[i];
      end
      main_sp_q <= main_sp_d;
      proc_sp_q <= proc_sp_d;
      link_q <= link_d;
      pc_q <= pc_d;
      psr_q <= psr_d;
      mask_all_q <= mask_all_d;
      fault_mask_q <= fault_mask_d;
      thresh_q <= thresh_d;
      ctrl_q <= ctrl_d;
      handler_q <= handler_d;
      user_q <= user_d;
      rdata_q <= rdata_d;
      gpr_rd_q <= gpr_rd_d;
      gpr_fault_q <= gpr_fault_d;
      accept_q <= accept_d;
      fault_q <= fault_d;
    end
  end

  assign bus_rdata_o = rdata_q;
  assign gpr_rd_data_o = gpr_rd_q;
  assign gpr_rd_fault_o = gpr_fault_q;
  assign program_counter_o = pc_q;
  assign program_status_o = psr_q;
  assign handler_mode_o = handler_q;
  assign user_level_o = user_q;
  assign exc_accept_o = accept_q;
  assign fault_o = fault_q;

  a_exec_bit_set: assert property (@(posedge clk_i) disable iff (reset_i) psr_q[EXEC_STATE_BIT])
    else $error("exec state bit cleared");
  a_sp_align: assert property (@(posedge clk_i) disable iff (reset_i) main_sp_q[1:0] == 2'h0 && proc_sp_q[1:0] == 2'h0)
    else $error("stack pointer misaligned");
  a_pc_align: assert property (@(posedge clk_i) disable iff (reset_i) !pc_q[0])
    else $error("program counter odd");
  a_call_link: assert property (@(posedge clk_i) disable iff (reset_i) call_i |=> link_q == $past(call_return_i))
    else $error("link not loaded on call");
  a_nmi_accept: assert property (@(posedge clk_i) disable iff (reset_i)
    exc_req_i.valid && exc_req_i.kind == CCS_EXC_NMI |=> exc_accept_o)
    else $error("nmi refused");
  a_fault_mask_hard: assert property (@(posedge clk_i) disable iff (reset_i)
    exc_req_i.valid && exc_req_i.kind == CCS_EXC_HARD && fault_mask_q |=> !exc_accept_o)
    else $error("hard fault passed fault mask");
  a_mask_all_irq: assert property (@(posedge clk_i) disable iff (reset_i)
    exc_req_i.valid && exc_req_i.kind == CCS_EXC_IRQ && mask_all_q |=> !exc_accept_o)
    else $error("irq passed global mask");
  a_thresh_block: assert property (@(posedge clk_i) disable iff (reset_i)
    exc_req_i.valid && exc_req_i.kind == CCS_EXC_IRQ && thresh_q != '0 && exc_req_i.prio >= thresh_q |=> !exc_accept_o)
    else $error("irq passed threshold");
  a_thresh_zero: assert property (@(posedge clk_i) disable iff (reset_i)
    exc_req_i.valid && exc_req_i.kind == CCS_EXC_IRQ && thresh_q == '0 && !mask_all_q && !fault_mask_q |=> exc_accept_o)
    else $error("zero threshold masked irq");
  a_handler_stack: assert property (@(posedge clk_i) disable iff (reset_i) handler_q |-> !use_proc_sp)
    else $error("process stack in handler");
  a_user_sr_fault: assert property (@(posedge clk_i) disable iff (reset_i)
    sr_we && user_now && sr_sel == SR_CONTROL |=> fault_o && $stable(ctrl_q))
    else $error("user control write not faulted");
  a_reset_clear: assert property (@(posedge clk_i) $fell(reset_i) |-> !mask_all_q && !fault_mask_q && thresh_q == '0 && ctrl_q == 2'h0)
    else $error("masks not cleared by reset");
  a_low16_gpr: assert property (@(posedge clk_i) disable iff (reset_i)
    gpr_wr_i.valid && !gpr_wr_i.wide && gpr_wr_i.num > LOW_REG_LAST && gpr_wr_i.num <= HIGH_REG_LAST |=> fault_o)
    else $error("narrow high register write accepted");

  // multi-step behaviours; entry, return, narrow read and handler control checks use named sequences
  sequence s_enter_taken;
    exc_enter_i;
  endsequence : s_enter_taken

  sequence s_return_taken;
    exc_return_i && !exc_enter_i;
  endsequence : s_return_taken

  sequence s_narrow_high_rd;
    !gpr_rd_wide_i && gpr_rd_num_i > LOW_REG_LAST && gpr_rd_num_i <= HIGH_REG_LAST;
  endsequence : s_narrow_high_rd

  sequence s_handler_ctrl_wr;
    sr_we && handler_q && sr_sel == SR_CONTROL;
  endsequence : s_handler_ctrl_wr

  a_enter_handler: assert property (@(posedge clk_i) disable iff (reset_i)
    s_enter_taken |=> handler_mode_o && !user_level_o
      && program_status_o[8:0] == $past(exc_num_i))
    else $error("exception entry not taken");

  a_return_thread: assert property (@(posedge clk_i) disable iff (reset_i)
    s_return_taken |=> !handler_mode_o
      && program_status_o[8:0] == 9'h000)
    else $error("exception return not taken");

  a_narrow_rd_fault: assert property (@(posedge clk_i) disable iff (reset_i)
    s_narrow_high_rd |=> gpr_rd_fault_o
      && gpr_rd_data_o == 32'h0)
    else $error("narrow high register read not faulted");

  a_low_rd_ok: assert property (@(posedge clk_i) disable iff (reset_i)
    gpr_rd_num_i <= LOW_REG_LAST
      |=> !gpr_rd_fault_o)
    else $error("low register read faulted");

  a_wide_rd_ok: assert property (@(posedge clk_i) disable iff (reset_i)
    gpr_rd_wide_i
      |=> !gpr_rd_fault_o)
    else $error("wide register read faulted");

  a_handler_ctrl: assert property (@(posedge clk_i) disable iff (reset_i)
    s_handler_ctrl_wr
      |=> !ctrl_q[CTRL_STACK_BIT])
    else $error("stack bit set in handler");

  a_bus_rd_idle: assert property (@(posedge clk_i) disable iff (reset_i)
    !bus_re_i
      |=> bus_rdata_o == 32'h0)
    else $error("read data outside read slot");

  a_pc_load: assert property (@(posedge clk_i) disable iff (reset_i)
    pc_load_i
      |=> program_counter_o == ($past(pc_next_i) & PC_ALIGN_MASK))
    else $error("program counter not loaded");

  a_hard_mask_all: assert property (@(posedge clk_i) disable iff (reset_i)
    exc_req_i.valid && exc_req_i.kind == CCS_EXC_HARD && mask_all_q && !fault_mask_q
      |=> exc_accept_o)
    else $error("hard fault refused under global mask");

  a_sp_rd_align: assert property (@(posedge clk_i) disable iff (reset_i)
    gpr_rd_num_i == REG_SP
      |=> gpr_rd_data_o[1:0] == 2'h0)
    else $error("stack read misaligned");
endmodule : ccs_core_state

// *** verif/ccs_exec_model.sv ***
// Purpose: stand-in for the execution and exception logic beside the core state block
// Assumes: one request per task call; answers sampled 1 ns after the taking edge
// Notes: released write data and request priority lines show the inverse of the last value, so stale data never matches; call and exception lines keep theirs
module ccs_exec_model
  import ccs_pkg::*;
(
  input wire logic clk_i,
  input wire logic [31:0] gpr_rd_data_i,
  input wire logic gpr_rd_fault_i,
  input wire logic exc_accept_i,
  output ccs_gpr_wr_t gpr_wr_o,
  output logic [3:0] gpr_rd_num_o,
  output logic gpr_rd_wide_o,
  output ccs_sr_wr_t sr_wr_o,
  output logic call_o,
  output logic [31:0] call_return_o,
  output logic pc_load_o,
  output logic [31:0] pc_next_o,
  output logic exc_enter_o,
  output logic [8:0] exc_num_o,
  output logic exc_return_o,
  output ccs_exc_req_t exc_req_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    gpr_wr_o = '0;
    gpr_rd_num_o = 4'h0;
    gpr_rd_wide_o = 1'b0;
    sr_wr_o = '0;
    {call_o, call_return_o, pc_load_o, pc_next_o} = '0;
    {exc_enter_o, exc_num_o, exc_return_o} = '0;
    exc_req_o = '0;
  end
  // pulse helper: drive after an edge, release after the taking edge
  task automatic gpr_write(input logic [3:0] n, input logic w, input logic [31:0] d);
    @(posedge clk_i);
    gpr_wr_o <= '{valid: 1'b1, wide: w, num: n, data: d};
    @(posedge clk_i);
    gpr_wr_o <= '{valid: 1'b0, wide: w, num: n, data: ~d};
    #1;
  endtask : gpr_write
  task automatic gpr_read(input logic [3:0] n, input logic w, output logic [31:0] d, output logic f);
    @(posedge clk_i);
    gpr_rd_num_o <= n;
    gpr_rd_wide_o <= w;
    @(posedge clk_i);
    #1;
    d = gpr_rd_data_i;
    f = gpr_rd_fault_i;
  endtask : gpr_read
  task automatic sr_write(input logic [3:0] s, input logic [31:0] d);
    @(posedge clk_i);
    sr_wr_o <= '{valid: 1'b1, sel: s, data: d};
    @(posedge clk_i);
    sr_wr_o <= '{valid: 1'b0, sel: s, data: ~d};
    #1;
  endtask : sr_write
  task automatic do_call(input logic [31:0] ra);
    @(posedge clk_i);
    call_o <= 1'b1;
    call_return_o <= ra;
    pc_load_o <= 1'b1;
    pc_next_o <= ra + 32'h00000101;
    @(posedge clk_i);
    call_o <= 1'b0;
    pc_load_o <= 1'b0;
    #1;
  endtask : do_call
  task automatic enter(input logic [8:0] n);
    @(posedge clk_i);
    exc_enter_o <= 1'b1;
    exc_num_o <= n;
    @(posedge clk_i);
    exc_enter_o <= 1'b0;
    #1;
  endtask : enter
  task automatic leave();
    @(posedge clk_i);
    exc_return_o <= 1'b1;
    @(posedge clk_i);
    exc_return_o <= 1'b0;
    #1;
  endtask : leave
  task automatic query(input logic [1:0] k, input logic [8:0] p, output logic acc);
    @(posedge clk_i);
    exc_req_o <= '{valid: 1'b1, kind: ccs_exc_kind_t'(k), prio: p};
    @(posedge clk_i);
    exc_req_o <= '{valid: 1'b0, kind: ccs_exc_kind_t'(k), prio: ~p};
    #1;
    acc = exc_accept_i;
  endtask : query
endmodule : ccs_exec_model

// *** verif/tb_top.sv ***
// Purpose: self-checking bench for the core state register block
// Assumes: bus master and execution model change inputs just after rising edges
// Notes: expected values are worked out here from field masks, never read back first
module tb_top import ccs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic [3:0] bus_addr = 4'h0;
  logic [31:0] bus_wdata = 32'h0;
  logic bus_we = 1'b0;
  logic bus_re = 1'b0;
  logic [31:0] bus_rdata, gpr_rd_data, pc_o, psr_o, d;
  logic gpr_rd_fault, handler_o, user_o, accept_o, fault_o, f, acc;
  ccs_gpr_wr_t gpr_wr;
  ccs_sr_wr_t sr_wr;
  ccs_exc_req_t exc_req;
  logic [3:0] rd_num;
  logic rd_wide, call, pc_load, exc_enter, exc_return;
  logic [31:0] call_ret, pc_next;
  logic [8:0] exc_num;
  int error_cnt = 0;
  int cmp_count = 0;
  always #5 clk_i = ~clk_i;
  ccs_core_state u_ccs_core_state (.clk_i(clk_i), .reset_i(reset_i), .gpr_wr_i(gpr_wr), .gpr_rd_num_i(rd_num),
    .gpr_rd_wide_i(rd_wide), .sr_wr_i(sr_wr), .call_i(call), .call_return_i(call_ret), .pc_load_i(pc_load),
    .pc_next_i(pc_next), .exc_enter_i(exc_enter), .exc_num_i(exc_num), .exc_return_i(exc_return),
    .exc_req_i(exc_req), .bus_addr_i(bus_addr), .bus_wdata_i(bus_wdata), .bus_we_i(bus_we), .bus_re_i(bus_re),
    .bus_rdata_o(bus_rdata), .gpr_rd_data_o(gpr_rd_data), .gpr_rd_fault_o(gpr_rd_fault),
    .program_counter_o(pc_o), .program_status_o(psr_o), .handler_mode_o(handler_o), .user_level_o(user_o),
    .exc_accept_o(accept_o), .fault_o(fault_o));
  ccs_exec_model u_ccs_exec_model (.clk_i(clk_i), .gpr_rd_data_i(gpr_rd_data), .gpr_rd_fault_i(gpr_rd_fault),
    .exc_accept_i(accept_o), .gpr_wr_o(gpr_wr), .gpr_rd_num_o(rd_num), .gpr_rd_wide_o(rd_wide), .sr_wr_o(sr_wr),
    .call_o(call), .call_return_o(call_ret), .pc_load_o(pc_load), .pc_next_o(pc_next), .exc_enter_o(exc_enter),
    .exc_num_o(exc_num), .exc_return_o(exc_return), .exc_req_o(exc_req));
  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp
  task automatic bus_wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge clk_i);
    bus_addr <= a;
    bus_wdata <= v;
    bus_we <= 1'b1;
    @(posedge clk_i);
    bus_we <= 1'b0;
    #1;
  endtask : bus_wr
  task automatic bus_chk(input logic [3:0] a, input logic [31:0] exp);
    @(posedge clk_i);
    bus_addr <= a;
    bus_re <= 1'b1;
    @(posedge clk_i);
    bus_re <= 1'b0;
    #1;
    cmp($sformatf("reg %0d", a), exp, bus_rdata);
  endtask : bus_chk
  // accept rule written out from the mask semantics
  function automatic logic exp_acc(int k, int p, int m, int fm, int t);
    if (k == 0) return 1'b1;
    if (fm != 0) return 1'b0;
    if (k == 1) return 1'b1;
    if (m != 0) return 1'b0;
    return !(k == 3 && t != 0 && p >= t);
  endfunction : exp_acc
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : end_of_test
  initial begin
    #200us;
    error_cnt++;
    end_of_test();
  end
  initial begin
    int mv[4] = '{0, 1, 0, 0};
    int fv[4] = '{0, 0, 1, 0};
    int tv[4] = '{0, 0, 0, 4};
    repeat (16) @(posedge clk_i);
    reset_i <= 1'b0;
    cmp("status out", PSR_RESET, psr_o);
    for (int a = 4; a <= 7; a++) bus_chk(a[3:0], 32'h0);
    bus_chk(SR_PSR_ALL, PSR_RESET);
    $display("test reset done");
    u_ccs_exec_model.gpr_write(4'h3, 1'b0, 32'h1234abcd);
    u_ccs_exec_model.gpr_read(4'h3, 1'b0, d, f);
    cmp("low reg narrow", 32'h1234abcd, d);
    u_ccs_exec_model.gpr_write(4'h9, 1'b1, 32'h00c0ffee);
    u_ccs_exec_model.gpr_read(4'h9, 1'b0, d, f);
    cmp("high reg narrow fault", 32'h1, {31'h0, f});
    u_ccs_exec_model.gpr_read(HIGH_REG_LAST, 1'b0, d, f);
    cmp("high reg narrow data", 32'h0, d);
    u_ccs_exec_model.gpr_read(4'h9, 1'b1, d, f);
    cmp("high reg wide", 32'h00c0ffee, d);
    u_ccs_exec_model.do_call(32'h00001235);
    u_ccs_exec_model.gpr_read(REG_LINK, 1'b1, d, f);
    cmp("return link", 32'h00001235, d);
    cmp("program counter", 32'h00001336 & PC_ALIGN_MASK, pc_o);
    $display("test general registers done");
    bus_wr(SR_APP, 32'hffffffff);
    bus_chk(SR_PSR_ALL, APP_FIELD_MASK | PSR_RESET);
    bus_wr(SR_EXEC, 32'h0600fc00);
    cmp("clear exec bit fault", 32'h1, {31'h0, fault_o});
    cmp("exec bit kept", 32'h1, {31'h0, psr_o[EXEC_STATE_BIT]});
    bus_wr(SR_EXEC, EXEC_FIELD_MASK);
    bus_chk(SR_EXEC, EXEC_FIELD_MASK);
    bus_chk(SR_APP, APP_FIELD_MASK);
    bus_wr(SR_PSR_ALL, 32'h09000000);
    bus_chk(SR_APP, 32'h08000000);
    $display("test status word done");
    for (int c = 0; c < 4; c++) begin
      bus_wr(SR_MASK_ALL, mv[c]);
      bus_wr(SR_FAULT_MASK, fv[c]);
      u_ccs_exec_model.sr_write(SR_THRESH, tv[c]);
      for (int k = 0; k < 4; k++) begin
        for (int p = 3; p <= 5; p++) begin
          u_ccs_exec_model.query(k[1:0], p[8:0], acc);
          cmp($sformatf("accept c%0d k%0d p%0d", c, k, p), exp_acc(k, p, mv[c], fv[c], tv[c]), acc);
        end
      end
    end
    u_ccs_exec_model.sr_write(SR_THRESH, 32'h0);
    $display("test masking done");
    u_ccs_exec_model.gpr_write(REG_SP, 1'b1, 32'h00001003);
    u_ccs_exec_model.gpr_read(REG_SP, 1'b1, d, f);
    cmp("stack aligned", 32'h00001003 & SP_ALIGN_MASK, d);
    bus_wr(SR_CONTROL, 32'h3);
    cmp("user level", 32'h1, {31'h0, user_o});
    u_ccs_exec_model.gpr_write(REG_SP, 1'b1, 32'h00002002);
    bus_chk(SR_PROC_SP, 32'h00002000);
    bus_chk(SR_MAIN_SP, 32'h00001000);
    bus_wr(SR_MASK_ALL, 32'h1);
    cmp("user write fault", 32'h1, {31'h0, fault_o});
    bus_chk(SR_MASK_ALL, 32'h0);
    bus_wr(SR_CONTROL, 32'h0);
    cmp("user control fault", 32'h1, {31'h0, fault_o});
    bus_chk(SR_CONTROL, 32'h3);
    u_ccs_exec_model.enter(9'h00b);
    cmp("handler mode", 32'h1, {31'h0, handler_o});
    cmp("handler privileged", 32'h0, {31'h0, user_o});
    bus_chk(SR_EXCNUM, 32'h0000000b);
    u_ccs_exec_model.gpr_read(REG_SP, 1'b1, d, f);
    cmp("handler main stack", 32'h00001000, d);
    bus_wr(SR_CONTROL, 32'h3);
    bus_chk(SR_CONTROL, 32'h1);
    bus_wr(SR_CONTROL, 32'h0);
    u_ccs_exec_model.leave();
    cmp("thread mode", 32'h0, {31'h0, handler_o});
    bus_chk(SR_EXCNUM, 32'h0);
    bus_wr(4'ha, 32'hffffffff);
    bus_chk(4'ha, 32'h0);
    $display("test stacks and modes done");
    end_of_test();
  end
endmodule : tb_top
